// [verilog/gpx_map.svh]
// Constants for the output logic and special input block.
// Assumes inclusion by the package, every module and the bench.
// Contract
// [RL1] Each output is driven by host command or by its internal logic block.
// [RL2] Logic block is the OR of at most two AND terms.
// [RL3] Term inputs come from first eight outputs, inputs and rail flags.
// [RL4] Each AND term selects one rail status type over chosen active rails.
// [RL5] Latched status types stay set until host or input clear.
// [RL6] Status set covers good, margin, faults, warnings, timeouts and latched forms.
// [RL7] First eight outputs feed sequencing as logic state, not pin level.
// [RL8] Power good for logic comes from monitored rails only.
// [RL9] Delay may apply on assertion, deassertion, both or neither.
// [RL10] Normal delay filters changes that revert before expiry.
// [RL11] Ignore option commits change and holds it at least the delay.
// [RL12] State-machine mode uses term 0 while true, term 1 while false.
// [RL13] At most one input pin per special input function.
// [RL14] Fault-enabled input deasserting is a fault; shutdown needs extra option.
// [RL15] Asserting the clear-source input clears latched rail flags.
// [RL16] Margin-enable input places margining rails in margined state.
// [RL17] Margin direction input selects low when asserted, high otherwise.
// [RL18] Each input pin polarity is configurable.
// [RL19] Output polarity sets pin level; open-drain high means released.
// [RL20] First three defined inputs form the rail-state selector.
// [RL21] Debug input suppresses alert, fault response and logging; code gates gpiFault only, not gpiShutdownReq or gpiNoRetry.
// [RL22] Shutdown function needs fault enable and responds without retry.
`ifndef GPX_MAP_SVH
`define GPX_MAP_SVH
`define GPX_NUM_OUT 10
`define GPX_NUM_IN 8
`define GPX_NUM_RAIL 10
`define GPX_NUM_DEP 8
`define GPX_NUM_STAT 32
`define GPX_NUM_LIVE 13
`define GPX_NUM_SEL 3
`define GPX_DLY_W 16
`define GPX_DLY_UNIT_NS 1000
`define GPX_CLK_NS 50
`define GPX_TICK_CYC ((`GPX_DLY_UNIT_NS + `GPX_CLK_NS - 1) / `GPX_CLK_NS)
`define GPX_ADDR_W 8
`define GPX_OFS_OUT_BASE 8'h00
`define GPX_OFS_IN_BASE 8'h40
`define GPX_OFS_MAN_OUT 8'h60
`define GPX_OFS_LCLR 8'h61
`define GPX_OFS_IN_STAT 8'h62
`define GPX_OFS_OUT_STAT 8'h63
`define GPX_OFS_FLT_STAT 8'h64
`define GPX_OFS_RAIL_MON 8'h65
`define GPX_OUT_STRIDE 6
`define GPX_CFG_MODE_B 0
`define GPX_CFG_SM_B 1
`define GPX_CFG_IGN_B 2
`define GPX_CFG_DA_B 3
`define GPX_CFG_DD_B 4
`define GPX_CFG_POL_B 5
`define GPX_CFG_OD_B 6
`define GPX_CFG_T0EN_B 7
`define GPX_CFG_T1EN_B 8
`define GPX_ICFG_POL_B 0
`define GPX_ICFG_FEN_B 1
`define GPX_ICFG_CLR_B 2
`define GPX_ICFG_MEN_B 3
`define GPX_ICFG_MDIR_B 4
`define GPX_ICFG_SHD_B 5
`define GPX_ICFG_DBG_B 6
`define GPX_ICFG_FPIN_B 7
`define GPX_ICFG_DEF_B 8
`endif

// [verilog/gpx_pkg.sv]
// Types for the output logic and special input block.
// Assumes the constants header is on the include path.
`include "gpx_map.svh"
package gpx_pkg;
   typedef logic [`GPX_NUM_DEP-1:0] gpx_dep_t;
   typedef logic [`GPX_NUM_IN-1:0] gpx_in_t;
   typedef logic [`GPX_NUM_RAIL-1:0] gpx_rail_t;
   // One AND term: inverted-sense masks and a status-type choice
   typedef struct packed {
      gpx_dep_t outMask;
      gpx_dep_t outInv;
      gpx_in_t inMask;
      gpx_in_t inInv;
      gpx_rail_t railMask;
      logic [4:0] statSel;
   } gpx_term_s;
   typedef struct packed {
      logic stateMach;
      logic ignoreDly;
      logic dlyAssert;
      logic dlyDeassert;
      logic polHigh;
      logic openDrain;
      logic useLogic;
      logic [15:0] dlyTicks;
   } gpx_ocfg_s;
   typedef enum {GPX_IDLE, GPX_WAIT} gpx_dly_e;
endpackage : gpx_pkg

// [verilog/gpx_out_chan.sv]
// One output channel: term evaluation, delay filter, polarity.
// Assumes config and inputs are in the mclk domain.
`timescale 1ns/1ps
`include "gpx_map.svh"
module gpx_out_chan
   import gpx_pkg::*;
#(
   parameter int DLY_W = 16,
   parameter int TICK_CYC = 20
) (
   input wire logic mclk, // Clock
   input wire logic sys_rst, // Sync reset
   input wire gpx_term_s term0, // AND term 0
   input wire gpx_term_s term1, // AND term 1
   input wire logic term0En, // Term 0 in use
   input wire logic term1En, // Term 1 in use
   input wire gpx_ocfg_s cfg, // Channel config
   input wire logic manLevel, // Host-commanded state
   input wire gpx_dep_t outState, // Logic state of first outputs
   input wire gpx_in_t inState, // Asserted inputs
   input wire logic [31:0][`GPX_NUM_RAIL-1:0] statVec, // Flags per type
   input wire logic tick, // Delay time base
   output logic logicState, // Output after delay
   output logic pinOut, // Pin level
   output logic pinOe // Pin drive enable
);
   logic state_r;
   logic [DLY_W-1:0] cnt_r;
   gpx_dly_e dly_r;
   logic t0;
   logic t1;
   logic raw;
   logic target;
   logic needDly;

   initial begin
      if (DLY_W < 1 || TICK_CYC < 1) $error("bad channel parameters");
   end

   function automatic logic evalTerm(input gpx_term_s t, input gpx_dep_t o, input gpx_in_t i,
                                     input logic [31:0][`GPX_NUM_RAIL-1:0] s);
      gpx_rail_t flags;
      flags = s[t.statSel];
      return (&(~t.outMask | (o ^ t.outInv))) & (&(~t.inMask | (i ^ t.inInv)))
             & (&(~t.railMask | flags)); // RL2 RL3 RL4
   endfunction : evalTerm

   always_comb begin
      t0 = term0En & evalTerm(term0, outState, inState, statVec);
      t1 = term1En & evalTerm(term1, outState, inState, statVec);
      if (cfg.stateMach) begin
         raw = state_r ? t0 : t1; // RL12
      end else begin
         raw = t0 | t1; // RL2
      end
      target = cfg.useLogic ? raw : manLevel; // RL1
      needDly = target ? cfg.dlyAssert : cfg.dlyDeassert; // RL9
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r <= 1'b0;
         cnt_r <= '0;
         dly_r <= GPX_IDLE;
      end else begin
         unique case (dly_r)
            GPX_IDLE: begin
               if (target != state_r) begin
                  if (!needDly || cfg.dlyTicks == 16'h0000) begin
                     state_r <= target;
                  end else begin
                     cnt_r <= cfg.dlyTicks[DLY_W-1:0];
                     dly_r <= GPX_WAIT;
                  end
               end
            end
            GPX_WAIT: begin
               if (!cfg.ignoreDly && target == state_r) begin
                  dly_r <= GPX_IDLE; // RL10
               end else if (tick) begin
                  if (cnt_r == {{(DLY_W-1){1'b0}}, 1'b1}) begin
                     state_r <= ~state_r; // RL11
                     dly_r <= GPX_IDLE;
                  end else begin
                     cnt_r <= cnt_r - 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_comb begin
      logicState = state_r; // RL7
      if (cfg.openDrain) begin
         pinOut = 1'b0;
         pinOe = ~(state_r ~^ cfg.polHigh); // RL19
      end else begin
         pinOut = state_r ~^ cfg.polHigh; // RL19
         pinOe = 1'b1;
      end
   end

   AST_FILTER: assert property (@(posedge mclk) disable iff (sys_rst) // RL10
      (dly_r == GPX_WAIT && !cfg.ignoreDly && target == state_r) |=> $stable(state_r))
      else $error("reverted change reached the output");
   AST_NODLY: assert property (@(posedge mclk) disable iff (sys_rst) // RL9
      (dly_r == GPX_IDLE && target != state_r && !needDly) |=> state_r == $past(target))
      else $error("undelayed change not taken");
endmodule : gpx_out_chan

// [verilog/gpx_gpio_logic.sv]
// Output logic blocks and special input functions of the sequencer.
// Assumes rail flags come synchronous to mclk; pins are asynchronous.
`timescale 1ns/1ps
`include "gpx_map.svh"
module gpx_gpio_logic
   import gpx_pkg::*;
#(
   parameter int NUM_OUT = `GPX_NUM_OUT,
   parameter int NUM_IN = `GPX_NUM_IN,
   parameter int DLY_W = `GPX_DLY_W
) (
   input wire logic mclk, // 20 MHz clock
   input wire logic sys_rst, // Sync reset
   input wire logic [`GPX_ADDR_W-1:0] regAddr, // Register address
   input wire logic [31:0] regWdata, // Write data
   input wire logic regWr, // Write strobe
   input wire logic regRd, // Read strobe
   output logic [31:0] regRdata, // Read data
   input wire logic [NUM_IN-1:0] general_input_pin, // Input pins
   output logic [NUM_OUT-1:0] general_output_pin, // Output pin levels
   output logic [NUM_OUT-1:0] outPinOe, // Output enables
   input wire logic [`GPX_NUM_LIVE-1:0][`GPX_NUM_RAIL-1:0] railLive, // Live flags per type
   input wire logic [`GPX_NUM_RAIL-1:0] railVmon, // Rail has voltage monitor
   input wire logic [`GPX_NUM_RAIL-1:0] railMarginEn, // Rail allows margining
   output logic [`GPX_NUM_DEP-1:0] seqDepState, // Logic state for sequencing
   output logic gpiFault, // Fault-enabled input deasserted
   output logic gpiShutdownReq, // Fault may shut rails down
   output logic gpiNoRetry, // Fault response skips retries
   output logic faultPinMode, // Fault-pin function active
   output logic [`GPX_NUM_RAIL-1:0] railMargined, // Rail in margined state
   output logic margin_direction_flag, // High selects margin low
   output logic debugMode, // Suppress alert, response, logging
   output logic [`GPX_NUM_SEL-1:0] railStateSel, // Pin-selected rail state
   output logic cfgConflict // Special function on two pins, or shutdown without fault enable
);
   localparam int TICK_CYC = `GPX_TICK_CYC;
   logic [NUM_IN-1:0] sync1_r;
   logic [NUM_IN-1:0] sync2_r;
   logic [NUM_IN-1:0] asserted;
   logic [NUM_IN-1:0] assertedPrev_r;
   logic [8:0] icfg_r [NUM_IN];
   logic [31:0] ocfg_r [NUM_OUT];
   gpx_term_s term_r [NUM_OUT][2];
   logic [NUM_OUT-1:0] manOut_r;
   logic [`GPX_NUM_LIVE-1:0][`GPX_NUM_RAIL-1:0] latch_r;
   logic [31:0][`GPX_NUM_RAIL-1:0] statVec;
   logic [NUM_OUT-1:0] logicState;
   logic [15:0] tickCnt_r;
   logic tick;
   logic hostClr;
   logic pinClr;
   logic [NUM_IN-1:0] fenMask;
   logic [NUM_IN-1:0] clrMask;
   logic [NUM_IN-1:0] menMask;
   logic [NUM_IN-1:0] mdirMask;
   logic [NUM_IN-1:0] shdMask;
   logic [NUM_IN-1:0] dbgMask;
   logic [NUM_IN-1:0] fpinMask;
   logic [NUM_IN-1:0] defMask;
   logic faultNow;
   logic [`GPX_NUM_SEL-1:0] selNxt;
   int selIdx;

   initial begin
      if (NUM_OUT < `GPX_NUM_DEP || NUM_OUT > 16 || NUM_IN < `GPX_NUM_SEL || NUM_IN > 16 || DLY_W > 16) begin
         $error("unsupported block parameters");
      end
   end

   // Pin synchronisers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= general_input_pin;
         sync2_r <= sync1_r;
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_IN; i++) begin
         asserted[i] = sync2_r[i] ~^ icfg_r[i][`GPX_ICFG_POL_B]; // RL18
         fenMask[i] = icfg_r[i][`GPX_ICFG_FEN_B];
         clrMask[i] = icfg_r[i][`GPX_ICFG_CLR_B];
         menMask[i] = icfg_r[i][`GPX_ICFG_MEN_B];
         mdirMask[i] = icfg_r[i][`GPX_ICFG_MDIR_B];
         shdMask[i] = icfg_r[i][`GPX_ICFG_SHD_B];
         dbgMask[i] = icfg_r[i][`GPX_ICFG_DBG_B];
         fpinMask[i] = icfg_r[i][`GPX_ICFG_FPIN_B];
         defMask[i] = icfg_r[i][`GPX_ICFG_DEF_B];
      end
   end

   // Delay time base
   always_ff @(posedge mclk) begin
      if (sys_rst || tick) begin
         tickCnt_r <= '0;
      end else begin
         tickCnt_r <= tickCnt_r + 16'h0001;
      end
   end
   assign tick = (tickCnt_r == 16'(TICK_CYC - 1));

   // Register writes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         manOut_r <= '0;
         for (int o = 0; o < NUM_OUT; o++) begin
            ocfg_r[o] <= '0;
            term_r[o][0] <= '0;
            term_r[o][1] <= '0;
         end
         for (int i = 0; i < NUM_IN; i++) begin
            icfg_r[i] <= '0;
         end
      end else if (regWr) begin
         for (int o = 0; o < NUM_OUT; o++) begin
            if (regAddr == 8'(`GPX_OUT_STRIDE * o)) ocfg_r[o] <= regWdata;
            if (regAddr == 8'(`GPX_OUT_STRIDE * o + 1)) term_r[o][0][46:15] <= regWdata;
            if (regAddr == 8'(`GPX_OUT_STRIDE * o + 2)) term_r[o][0][14:0] <= regWdata[14:0];
            if (regAddr == 8'(`GPX_OUT_STRIDE * o + 3)) term_r[o][1][46:15] <= regWdata;
            if (regAddr == 8'(`GPX_OUT_STRIDE * o + 4)) term_r[o][1][14:0] <= regWdata[14:0];
         end
         for (int i = 0; i < NUM_IN; i++) begin
            if (regAddr == 8'(`GPX_OFS_IN_BASE + i)) icfg_r[i] <= regWdata[8:0];
         end
         if (regAddr == `GPX_OFS_MAN_OUT) manOut_r <= regWdata[NUM_OUT-1:0]; // RL1
      end
   end

   assign hostClr = regWr && regAddr == `GPX_OFS_LCLR && regWdata[0];
   assign pinClr = |(clrMask & asserted & ~assertedPrev_r); // RL15

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         assertedPrev_r <= '0;
      end else begin
         assertedPrev_r <= asserted;
      end
   end

   // Latched status flags; a new event wins over a clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         latch_r <= '0;
      end else begin
         for (int k = 3; k < `GPX_NUM_LIVE; k++) begin
            latch_r[k] <= railLive[k] | ((hostClr || pinClr) ? '0 : latch_r[k]); // RL5 RL15
         end
         latch_r[2:0] <= '0;
      end
   end

   // Status vector: live types 0..12, latched forms 13..22
   always_comb begin
      statVec = '0;
      statVec[0] = railLive[0] & railVmon; // RL8
      for (int k = 1; k < `GPX_NUM_LIVE; k++) begin
         statVec[k] = railLive[k]; // RL6
      end
      for (int k = 3; k < `GPX_NUM_LIVE; k++) begin
         statVec[k + 10] = latch_r[k]; // RL6
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++) begin : gChan
         gpx_ocfg_s cfg;
         assign cfg = '{stateMach: ocfg_r[g][`GPX_CFG_SM_B], ignoreDly: ocfg_r[g][`GPX_CFG_IGN_B],
                        dlyAssert: ocfg_r[g][`GPX_CFG_DA_B], dlyDeassert: ocfg_r[g][`GPX_CFG_DD_B],
                        polHigh: ocfg_r[g][`GPX_CFG_POL_B], openDrain: ocfg_r[g][`GPX_CFG_OD_B],
                        useLogic: ocfg_r[g][`GPX_CFG_MODE_B], dlyTicks: ocfg_r[g][31:16]};
         gpx_out_chan #(.DLY_W(DLY_W), .TICK_CYC(TICK_CYC)) uChan (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .term0(term_r[g][0]),
            .term1(term_r[g][1]),
            .term0En(ocfg_r[g][`GPX_CFG_T0EN_B]),
            .term1En(ocfg_r[g][`GPX_CFG_T1EN_B]),
            .cfg(cfg),
            .manLevel(manOut_r[g]),
            .outState(logicState[`GPX_NUM_DEP-1:0]), // RL3
            .inState(asserted),
            .statVec(statVec),
            .tick(tick),
            .logicState(logicState[g]),
            .pinOut(general_output_pin[g]),
            .pinOe(outPinOe[g])
         );
      end
   endgenerate

   assign seqDepState = logicState[`GPX_NUM_DEP-1:0]; // RL7

   // Special input functions
   always_comb begin
      faultNow = |(fenMask & ~asserted); // RL14
      selNxt = '0;
      selIdx = 0;
      for (int i = 0; i < NUM_IN; i++) begin
         if (defMask[i] && selIdx < `GPX_NUM_SEL) begin
            selNxt[selIdx] = asserted[i]; // RL20
            selIdx = selIdx + 1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         gpiFault <= 1'b0;
         gpiShutdownReq <= 1'b0;
         gpiNoRetry <= 1'b0;
         faultPinMode <= 1'b0;
         railMargined <= '0;
         margin_direction_flag <= 1'b0;
         debugMode <= 1'b0;
         railStateSel <= '0;
         cfgConflict <= 1'b0;
      end else begin
         debugMode <= |(dbgMask & asserted); // RL21
         gpiFault <= faultNow && !(|(dbgMask & asserted)); // RL21
         gpiShutdownReq <= faultNow && (|(fenMask & (shdMask | fpinMask))); // RL14
         gpiNoRetry <= faultNow && (|(fenMask & shdMask)); // RL22
         faultPinMode <= |(fenMask & fpinMask);
         railMargined <= (|(menMask & asserted)) ? railMarginEn : '0; // RL16
         margin_direction_flag <= (|(menMask & asserted)) && (|(mdirMask & asserted)); // RL17
         railStateSel <= selNxt; // RL20
         cfgConflict <= !$onehot0(fenMask) || !$onehot0(clrMask) || !$onehot0(menMask) // RL13
            || !$onehot0(mdirMask) || !$onehot0(shdMask) || !$onehot0(dbgMask) || !$onehot0(fpinMask)
            || |(shdMask & ~fenMask); // RL22
      end
   end

   // Read port
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         regRdata <= '0;
      end else begin
         regRdata <= '0;
         if (regRd) begin
            for (int o = 0; o < NUM_OUT; o++) begin
               if (regAddr == 8'(`GPX_OUT_STRIDE * o)) regRdata <= ocfg_r[o];
            end
            for (int i = 0; i < NUM_IN; i++) begin
               if (regAddr == 8'(`GPX_OFS_IN_BASE + i)) regRdata <= {23'h0, icfg_r[i]};
            end
            if (regAddr == `GPX_OFS_MAN_OUT) regRdata <= 32'(manOut_r);
            if (regAddr == `GPX_OFS_IN_STAT) regRdata <= 32'(asserted);
            if (regAddr == `GPX_OFS_OUT_STAT) regRdata <= 32'(logicState);
            if (regAddr == `GPX_OFS_FLT_STAT) regRdata <= {29'h0, cfgConflict, debugMode, gpiFault};
            if (regAddr == `GPX_OFS_RAIL_MON) regRdata <= 32'(railMargined);
         end
      end
   end

   AST_MARGIN: assert property (@(posedge mclk) disable iff (sys_rst) // RL16
      !(|(menMask & asserted)) |=> railMargined == '0)
      else $error("margin without enable input");
   AST_MDIR: assert property (@(posedge mclk) disable iff (sys_rst) // RL17
      margin_direction_flag |-> $past(|(menMask & asserted)))
      else $error("direction set without margin enable");
   AST_DEBUG: assert property (@(posedge mclk) disable iff (sys_rst) // RL21
      debugMode |-> !gpiFault)
      else $error("fault raised in debug mode");
   AST_LCLR: assert property (@(posedge mclk) disable iff (sys_rst) // RL15
      (pinClr && railLive[3] == '0) |=> latch_r[3] == '0)
      else $error("latched flag survived clear");
   AST_LHOLD: assert property (@(posedge mclk) disable iff (sys_rst) // RL5
      (!hostClr && !pinClr) |=> ((latch_r[5] & $past(latch_r[5])) == $past(latch_r[5])))
      else $error("latched flag dropped without clear");
   AST_SHD: assert property (@(posedge mclk) disable iff (sys_rst) // RL14
      gpiShutdownReq |-> gpiFault || $past(|(dbgMask & asserted)))
      else $error("shutdown without fault");
   AST_PG: assert property (@(posedge mclk) disable iff (sys_rst) // RL8
      (statVec[0] & ~railVmon) == '0)
      else $error("unmonitored power good used");
   AST_NORETRY: assert property (@(posedge mclk) disable iff (sys_rst) // RL22
      gpiNoRetry |-> gpiShutdownReq)
      else $error("no-retry without shutdown");
endmodule : gpx_gpio_logic

// [tb/gpx_board_model.sv]
// Board-side model: input pin drivers and rail status sources.
// Assumes the bench requests pin levels; changes land just after mclk edges.
`timescale 1ns/1ps
`include "gpx_map.svh"
module gpx_board_model
   import gpx_pkg::*;
(
   input wire logic mclk, // Clock
   input wire gpx_in_t pinReq, // Wanted pin levels
   input wire gpx_rail_t marginReq, // Wanted margining rails
   output gpx_in_t pinDrv, // Input pin levels
   output logic [`GPX_NUM_LIVE-1:0][`GPX_NUM_RAIL-1:0] liveDrv, // Live rail flags
   output gpx_rail_t vmonDrv, // Rails with voltage monitor
   output gpx_rail_t marginEnDrv // Rails allowing margining
);
   initial begin
      pinDrv = 8'h00;
      marginEnDrv = 10'h000;
   end
   // Pins move right after an edge, like a board driver clocked nearby
   always @(posedge mclk) begin
      pinDrv <= pinReq;
      marginEnDrv <= marginReq;
   end
   // Last rail has no voltage monitor
   assign vmonDrv = 10'h1FF;
   assign liveDrv = {13{10'h155}};
endmodule : gpx_board_model

// [tb/test_gpx_gpio_logic.sv]
// Self-checking bench for the output logic and special input block.
// Assumes the board model drives input pins and rail flags.
`timescale 1ns/1ps
`include "gpx_map.svh"
module test_gpx_gpio_logic;
   import gpx_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h00000000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   gpx_in_t pinReq = 8'h00;
   gpx_rail_t marginReq = 10'h2B5;
   gpx_in_t inPin;
   gpx_rail_t vmon, marginEn, margined;
   logic [12:0][9:0] live;
   logic [9:0] outPin, outOe;
   logic [7:0] depState;
   logic fault, shutReq, noRetry, fPin, mDir, dbg, conflict;
   logic [2:0] stateSel;
   int n_fail = 0;
   int n_compared = 0;
   int cyc = 0;

   always #25 mclk = ~mclk;

   gpx_board_model i_gpx_board_model (.mclk(mclk), .pinReq(pinReq), .marginReq(marginReq), .pinDrv(inPin),
      .liveDrv(live), .vmonDrv(vmon), .marginEnDrv(marginEn));

   gpx_gpio_logic i_gpx_gpio_logic (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .general_input_pin(inPin),
      .general_output_pin(outPin), .outPinOe(outOe), .railLive(live), .railVmon(vmon),
      .railMarginEn(marginEn), .seqDepState(depState), .gpiFault(fault), .gpiShutdownReq(shutReq),
      .gpiNoRetry(noRetry), .faultPinMode(fPin), .railMargined(margined), .margin_direction_flag(mDir),
      .debugMode(dbg), .railStateSel(stateSel), .cfgConflict(conflict));

   task automatic conclude();
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk

   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      chk("regRdata", e, regRdata);
   endtask : rd

   task automatic pins(input logic [7:0] v);
      @(posedge mclk);
      pinReq <= v;
      tk(8);
   endtask : pins

   // Output 1 must keep one level for n cycles
   task automatic hold(input logic lv, input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         tk(1);
         if (outPin[1] !== lv) bad = 1'b1;
      end
      chk("pinHeld", 0, bad);
   endtask : hold

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         conclude();
      end
   end

   initial begin
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      tk(2);
      chk("pinOut0", 1, outPin[0]);
      chk("pinOe0", 1, outOe[0]);
      rd(8'h62, 32'h000000FF);
      rd(8'hF0, 32'h00000000);
      // Host-commanded output 0
      wr(8'h60, 32'h00000001);
      tk(4);
      chk("pinOut0", 0, outPin[0]);
      chk("depState", 8'h01, depState);
      rd(8'h63, 32'h00000001);
      wr(8'h00, 32'h00000040);
      tk(4);
      chk("pinOe0", 1, outOe[0]);
      chk("pinOut0", 0, outPin[0]);
      wr(8'h60, 32'h00000000);
      tk(4);
      chk("pinOe0", 0, outOe[0]);
      wr(8'h00, 32'h00000020);
      wr(8'h60, 32'h00000001);
      tk(4);
      chk("pinOut0", 1, outPin[0]);
      // Output 1 from logic: term enables, state machine
      wr(8'h06, 32'h00000121);
      tk(4);
      chk("pinOut1", 1, outPin[1]);
      wr(8'h06, 32'h00000021);
      tk(4);
      chk("pinOut1", 0, outPin[1]);
      wr(8'h06, 32'h000000A3);
      tk(6);
      chk("pinOut1", 0, outPin[1]);
      wr(8'h06, 32'h000001A3);
      tk(6);
      chk("pinOut1", 1, outPin[1]);
      wr(8'h06, 32'h00000021);
      tk(4);
      // Three-tick delays, glitch filter and ignore option
      wr(8'h06, 32'h000300B9);
      tk(18);
      wr(8'h06, 32'h00030039);
      hold(0, 120);
      wr(8'h06, 32'h000300B9);
      hold(0, 36);
      tk(34);
      chk("pinOut1", 1, outPin[1]);
      wr(8'h06, 32'h00030039);
      hold(1, 36);
      tk(34);
      chk("pinOut1", 0, outPin[1]);
      wr(8'h06, 32'h000300BD);
      tk(18);
      wr(8'h06, 32'h0003003D);
      tk(50);
      chk("pinOut1", 1, outPin[1]);
      hold(1, 8);
      tk(120);
      chk("pinOut1", 0, outPin[1]);
      // Input polarity
      wr(8'h40, 32'h00000001);
      tk(6);
      rd(8'h62, 32'h000000FE);
      pins(8'h01);
      rd(8'h62, 32'h000000FF);
      // Margin enable and direction
      wr(8'h41, 32'h00000009);
      wr(8'h42, 32'h00000011);
      pins(8'h07);
      chk("railMargined", 10'h2B5, margined);
      chk("marginDir", 1, mDir);
      pins(8'h03);
      chk("marginDir", 0, mDir);
      pins(8'h01);
      chk("railMargined", 0, margined);
      // Fault input, shutdown, fault pin, debug
      wr(8'h43, 32'h00000003);
      pins(8'h09);
      chk("gpiFault", 0, fault);
      pins(8'h01);
      chk("gpiFault", 1, fault);
      chk("shutdown", 0, shutReq);
      wr(8'h43, 32'h00000023);
      tk(4);
      chk("shutdown", 1, shutReq);
      chk("noRetry", 1, noRetry);
      wr(8'h43, 32'h00000083);
      tk(4);
      chk("faultPin", 1, fPin);
      chk("shutdown", 1, shutReq);
      wr(8'h43, 32'h00000021);
      tk(4);
      chk("shutdown", 0, shutReq);
      wr(8'h43, 32'h00000003);
      wr(8'h44, 32'h00000041);
      pins(8'h11);
      chk("debugMode", 1, dbg);
      chk("gpiFault", 0, fault);
      pins(8'h01);
      chk("gpiFault", 1, fault);
      // Same function on two pins
      wr(8'h45, 32'h00000008);
      tk(4);
      chk("conflict", 1, conflict);
      wr(8'h45, 32'h00000000);
      tk(4);
      chk("conflict", 0, conflict);
      // Selector from first three defined inputs
      wr(8'h45, 32'h00000101);
      wr(8'h46, 32'h00000101);
      wr(8'h47, 32'h00000101);
      pins(8'hA1);
      chk("stateSel", 3'b101, stateSel);
      wr(8'h40, 32'h00000101);
      tk(6);
      chk("stateSel", 3'b011, stateSel);
      // Output 2 from real terms: input, rail flag, latched flag, output state
      wr(8'h0C, 32'h000000A1);
      wr(8'h0D, 32'h00000100);
      wr(8'h0E, 32'h00000020);
      tk(4);
      chk("pinOut2", 1, outPin[2]);
      pins(8'hA0);
      chk("pinOut2", 0, outPin[2]);
      wr(8'h0E, 32'h00000040);
      pins(8'hA1);
      chk("pinOut2", 0, outPin[2]);
      wr(8'h0E, 32'h0000002D);
      tk(4);
      chk("pinOut2", 1, outPin[2]);
      wr(8'h61, 32'h00000001);
      tk(4);
      chk("pinOut2", 1, outPin[2]);
      wr(8'h0E, 32'h00000020);
      wr(8'h0D, 32'h02020100);
      tk(4);
      chk("pinOut2", 1, outPin[2]);
      wr(8'h0D, 32'h02000100);
      tk(4);
      chk("pinOut2", 0, outPin[2]);
      conclude();
   end
endmodule : test_gpx_gpio_logic
